/* File: verif/mem_model.sv */
// Purpose: Memory seen by the transfer channels
// Assumes: Request held until a one-cycle ack
// Notes: Ack delay varies 0 to 3 cycles; idle read data keeps changing
`timescale 1ns/100ps
`default_nettype none

module mem_model (
  // Clock
  input wire logic ref_clk_i,
  // Request
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  // Answer
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic [31:0] wmem [0:63];
  int wait_n;
  initial
  begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 32'h0000_0000;
    wait_n = 0;
  end
  always @(negedge ref_clk_i)
  begin
    if (mem_ack_o || !mem_req_i)
    begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
    end
    else if (wait_n > 0)
      wait_n <= wait_n - 1;
    else
    begin
      mem_ack_o <= 1'b1;
      wait_n <= $urandom % 4;
      if (mem_we_i)
        wmem[mem_addr_i[7:2]] <= mem_wdata_i;
      else
        mem_rdata_o <= {mem_addr_i[15:0], ~mem_addr_i[15:0]};
    end
  end
endmodule // mem_model

`default_nettype wire

/* File: verif/pri_checker.sv */
// Purpose: Port checks of the peripheral register front end
// Assumes: One clock, rst_i synchronous and active high
// Notes: Bound to the design from the tb file
`timescale 1ns/100ps
`default_nettype none

module pri_checker #(
  parameter int WIN_BITS = 14
) (
  // Bus
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Channels
  input wire logic tx_valid_o,
  input wire logic [31:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic mem_req_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_ack_i
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [WIN_BITS-3:0] word;
  logic rd_done;
  assign word = paddr_i[WIN_BITS-1:2];
  assign rd_done = pready_o && !pwrite_i;

  chk_ready_next: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  chk_no_slverr: assert property (!pslverr_o)
    else $error("pslverr raised");
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside access");
  chk_wo_zero: assert property (rd_done && (word == 0 || word == 2 || word == 3) |-> prdata_o == 32'h0000_0000)
    else $error("write-only register read nonzero");
  chk_mask_unused: assert property (rd_done && word == 4 |-> prdata_o[31:6] == 26'h000_0000)
    else $error("unused mask bits nonzero");
  chk_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("memory request dropped or moved");
  chk_mem_gap: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("memory request kept after ack");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx item changed while stalled");
endmodule // pri_checker

`default_nettype wire

/* File: verif/tb.sv */
// Purpose: Self-checking bench of the peripheral register front end
// Assumes: Bus driven at the falling edge, seed 93
// Notes: Memory side answered by mem_model
`timescale 1ns/100ps
`default_nettype none
`include "periph_reg_map.svh"

module tb;
  logic ref_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
  logic rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, mem_req_o, mem_we_o, mem_ack_i;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rx_data_i, tx_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [31:0] rd, v, rx_item [0:2], txq [$];
  logic [5:0] m;
  int fail_count, check_count, i;

  peripheral_register_interface dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i));
  mem_model mem_u (.ref_clk_i(ref_clk_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic fail_wait(input string w);
    fail_count++;
    $display("ERROR %s expected done seen timeout", w);
    close_out;
  endtask

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask

  // Looks at a handshake at the falling edge, where it is settled; the next rising edge completes it
  task automatic wait_hi(ref logic s, input int lim, input string w);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    if (s !== 1'b1)
      fail_wait(w);
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(negedge ref_clk_i);
    psel_i = 1'b1;
    pwrite_i = wr;
    paddr_i = a;
    pwdata_i = d;
    @(negedge ref_clk_i);
    penable_i = 1'b1;
    wait_hi(pready_o, 3, "pready");
    rd = prdata_o;
    @(negedge ref_clk_i);
    psel_i = 1'b0;
    penable_i = 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input string w);
    apb(1'b0, a, $urandom);
    chk(w, e, rd);
  endtask

  task automatic poll_zero(input logic [31:0] a, input string w);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end
    while (rd !== 32'h0000_0000 && n < 60);
    chk(w, 32'h0000_0000, rd);
  endtask

  task automatic rx_send(input logic [31:0] d);
    @(negedge ref_clk_i);
    rx_valid_i = 1'b1;
    rx_data_i = d;
    wait_hi(rx_ready_o, 40, "rx_ready");
    @(negedge ref_clk_i);
    rx_valid_i = 1'b0;
    rx_data_i = ~d;
  endtask

  // Receiver side of the tx stream stalls at random
  always @(negedge ref_clk_i)
    tx_ready_i <= ($urandom % 3) != 0;
  always @(posedge ref_clk_i)
    if (tx_valid_o === 1'b1 && tx_ready_i)
      txq.push_back(tx_data_o);

  initial
  begin
    #500000;
    fail_wait("run");
  end

  initial
  begin
    v = $urandom(93);
    {psel_i, penable_i, pwrite_i, rx_valid_i} = 4'h0;
    {paddr_i, pwdata_i, rx_data_i} = {3{32'h0000_0000}};
    rst_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    rchk(`OFF_MODE, 32'h0000_0000, "mode");
    rchk(`OFF_STATUS, 32'h0000_000B, "status");
    rchk(`OFF_RX_PTR, 32'h0000_0000, "rx_ptr");
    apb(1'b1, `OFF_STATUS, 32'h0000_003F);
    apb(1'b1, `OFF_IRQ_MASK, 32'h0000_003F);
    rchk(`OFF_STATUS, 32'h0000_000B, "status");
    rchk(`OFF_IRQ_MASK, 32'h0000_0000, "mask");
    for (i = 0; i < 4; i++)
    begin
      v = $urandom;
      apb(1'b1, `OFF_MODE | (v & 32'hFFFF_C003), v & 32'h0000_0003);
      rchk(`OFF_MODE + 32'h0000_4000 * i, v & 32'h0000_0003, "mode");
    end
    m = 6'h00;
    for (i = 0; i < 8; i++)
    begin
      v = (i == 2 || i == 5) ? 32'h0000_0000 : $urandom & 32'h0000_003F;
      apb(1'b1, i[0] ? `OFF_IRQ_DIS : `OFF_IRQ_EN, v);
      m = i[0] ? m & ~v[5:0] : m | v[5:0];
      rchk(`OFF_IRQ_MASK, {26'h000_0000, m}, "mask");
    end
    rchk(`OFF_CTRL, 32'h0000_0000, "ctrl");
    rchk(`OFF_IRQ_EN, 32'h0000_0000, "irq_en");
    rchk(`OFF_IRQ_DIS, 32'h0000_0000, "irq_dis");
    apb(1'b1, `OFF_IRQ_DIS, 32'h0000_003F);
    apb(1'b1, `OFF_IRQ_EN, 32'h0000_0034);
    @(negedge ref_clk_i);
    chk("irq", 1'b0, irq_o);
    apb(1'b1, `OFF_IRQ_EN, 32'h0000_0002);
    @(negedge ref_clk_i);
    chk("irq", 1'b1, irq_o);
    for (i = 0; i < 3; i++)
      rx_item[i] = $urandom;
    apb(1'b1, `OFF_MODE, 32'h0000_0002);
    rx_send(rx_item[0]);
    rx_send(rx_item[1]);
    @(negedge ref_clk_i);
    chk("rx_ready full", 1'b0, rx_ready_o);
    rchk(`OFF_STATUS, 32'h0000_000F, "status");
    apb(1'b1, `OFF_RX_PTR, 32'h0000_0040);
    apb(1'b1, `OFF_RX_CNT, 32'h0000_0003);
    rchk(`OFF_RX_CNT, 32'h0000_0003, "rx_cnt");
    apb(1'b1, `OFF_CTRL, 32'h0000_0001);
    rx_send(rx_item[2]);
    poll_zero(`OFF_RX_CNT, "rx_cnt");
    rchk(`OFF_RX_PTR, 32'h0000_004C, "rx_ptr");
    for (i = 0; i < 3; i++)
      chk("rx_mem", rx_item[i], mem_u.wmem[16 + i]);
    apb(1'b1, `OFF_CTRL, 32'h0000_0000);
    rchk(`OFF_STATUS, 32'h0000_001B, "status");
    apb(1'b1, `OFF_CTRL, 32'h0000_0002);
    rchk(`OFF_STATUS, 32'h0000_000B, "status");
    apb(1'b1, `OFF_MODE, 32'h0000_0000);
    apb(1'b1, `OFF_TX_PTR, 32'h0000_0101);
    apb(1'b1, `OFF_TX_CNT, 32'h0000_0002);
    apb(1'b1, `OFF_CTRL, 32'h0000_0004);
    poll_zero(`OFF_TX_CNT, "tx_cnt");
    rchk(`OFF_TX_PTR, 32'h0000_0103, "tx_ptr");
    for (i = 0; i < 40 && txq.size() < 2; i++)
      @(negedge ref_clk_i);
    chk("tx_items", 32'h0000_0002, txq.size());
    for (i = 0; i < txq.size(); i++)
      chk("tx_data", exp_rd(32'h0000_0101 + i), txq[i]);
    close_out;
  end
endmodule // tb

bind peripheral_register_interface pri_checker #(.WIN_BITS(WIN_BITS)) chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
  .tx_ready_i(tx_ready_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i));

`default_nettype wire

/* File: verilog/periph_reg_map.svh */
// Purpose: Register offsets, field positions, reset values of the peripheral register front end
// Assumes: Offsets are byte offsets inside the peripheral window
// Notes: Definitions only
`ifndef PERIPH_REG_MAP_SVH
`define PERIPH_REG_MAP_SVH

// Window sizes in address bits
`define WIN_BITS_PERIPH 14
`define WIN_BITS_ICU 12

// Register offsets
`define OFF_CTRL 32'h0000_0000
`define OFF_MODE 32'h0000_0004
`define OFF_IRQ_EN 32'h0000_0008
`define OFF_IRQ_DIS 32'h0000_000C
`define OFF_IRQ_MASK 32'h0000_0010
`define OFF_STATUS 32'h0000_0014
`define OFF_RX_PTR 32'h0000_0030
`define OFF_RX_CNT 32'h0000_0034
`define OFF_TX_PTR 32'h0000_0038
`define OFF_TX_CNT 32'h0000_003C

// Control command bits
`define CTRL_RX_START 0
`define CTRL_RX_STOP 1
`define CTRL_TX_START 2
`define CTRL_TX_STOP 3

// Mode fields
`define MODE_SIZE_LSB 0
`define MODE_SIZE_MSB 1

// Status bits
`define ST_END_RX 0
`define ST_END_TX 1
`define ST_RX_PENDING 2
`define ST_TX_EMPTY 3
`define ST_RX_ON 4
`define ST_TX_ON 5
`define ST_WIDTH 6

// Reset values
`define RST_MODE 2'h0
`define RST_MASK 6'h00
`define RST_PTR 32'h0000_0000
`define RST_CNT 16'h0000

`endif

/* File: verilog/periph_reg_pkg.sv */
// Purpose: Types of the peripheral register front end
// Assumes: Nothing
// Notes: Constants live in periph_reg_map.svh
package periph_reg_pkg;

  // Channel engine states; idle -> rx write flips one bit, idle -> tx read flips both bits
  typedef enum logic [1:0]
  {
    CH_IDLE = 2'b00,
    CH_RX_WR = 2'b01,
    CH_TX_RD = 2'b11
  } chan_state_t;

  // Item size held in the mode register
  typedef enum logic [1:0]
  {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } item_size_t;

endpackage

/* File: verilog/peripheral_register_interface.sv */
// Purpose: Register front end of one serial-port peripheral with its rx/tx transfer channel pair
// Assumes: 32-bit APB slave, one clock, synchronous active-high reset
// Notes: Two instances give the four channels of two serial ports
`timescale 1ns/100ps
`default_nettype none
`include "periph_reg_map.svh"

module peripheral_register_interface #(
  parameter int WIN_BITS = `WIN_BITS_PERIPH
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupt source to the interrupt controller unit
  output logic irq_o,
  // Received items from the serial receiver
  input wire logic rx_valid_i,
  input wire logic [31:0] rx_data_i,
  output logic rx_ready_o,
  // Items for the serial transmitter
  output logic tx_valid_o,
  output logic [31:0] tx_data_o,
  input wire logic tx_ready_i,
  // Memory port of the transfer channels
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);

  // Pointer step for one item of the given size
  function automatic logic [31:0] item_step(input logic [1:0] size);
    case (size)
      periph_reg_pkg::SZ_BYTE: item_step = 32'h0000_0001;
      periph_reg_pkg::SZ_HALF: item_step = 32'h0000_0002;
      default: item_step = 32'h0000_0004;
    endcase
  endfunction

  // Bus side state
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg;
  logic irq_reg, irq_next;
  // Configuration and channel state
  logic [1:0] mode_reg, mode_next;
  logic [`ST_WIDTH-1:0] mask_reg, mask_next;
  logic rx_on_reg, rx_on_next;
  logic tx_on_reg, tx_on_next;
  logic [31:0] rx_ptr_reg, rx_ptr_next;
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [31:0] tx_ptr_reg, tx_ptr_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  periph_reg_pkg::chan_state_t state_reg, state_next;
  logic mem_req_reg, mem_req_next;
  logic mem_we_reg, mem_we_next;
  logic [31:0] mem_addr_reg, mem_addr_next;
  logic [31:0] mem_wdata_reg, mem_wdata_next;
  logic tx_valid_reg, tx_valid_next;
  logic [31:0] tx_data_reg, tx_data_next;
  // Buffer drain side
  logic buf_valid;
  logic [31:0] buf_data;
  logic buf_pop;
  // Decode
  logic [31:0] win_mask;
  logic [31:0] offset;
  logic setup, wr_done;
  logic [`ST_WIDTH-1:0] status;
  logic [31:0] rd_mux;

  two_entry_buffer #(
    .WIDTH(32)
  ) u_rx_buffer (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_valid_i),
    .in_data_i(rx_data_i),
    .in_ready_o(rx_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(buf_pop)
  );

  always_comb
  begin
    // Window offset; low two bits forced off so every access is a word
    win_mask = (32'h0000_0001 << WIN_BITS) - 32'h0000_0001;
    offset = paddr_i & win_mask & 32'hFFFF_FFFC;
    setup = psel_i & ~penable_i & ~pready_reg;
    wr_done = psel_i & penable_i & pready_reg & pwrite_i;

    // Live status; end bits are high while the count sits at zero
    status = '0;
    status[`ST_END_RX] = (rx_cnt_reg == 16'h0000);
    status[`ST_END_TX] = (tx_cnt_reg == 16'h0000);
    status[`ST_RX_PENDING] = buf_valid;
    status[`ST_TX_EMPTY] = ~tx_valid_reg;
    status[`ST_RX_ON] = rx_on_reg;
    status[`ST_TX_ON] = tx_on_reg;

    // Read mux; control, enable and disable registers read zero, unused bits read zero
    case (offset)
      `OFF_MODE: rd_mux = {30'h0000_0000, mode_reg};
      `OFF_IRQ_MASK: rd_mux = {26'h000_0000, mask_reg};
      `OFF_STATUS: rd_mux = {26'h000_0000, status};
      `OFF_RX_PTR: rd_mux = rx_ptr_reg;
      `OFF_RX_CNT: rd_mux = {16'h0000, rx_cnt_reg};
      `OFF_TX_PTR: rd_mux = tx_ptr_reg;
      `OFF_TX_CNT: rd_mux = {16'h0000, tx_cnt_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    // Zero-wait APB with registered answer: data captured in setup, ready in access
    pready_next = setup;
    prdata_next = (setup & ~pwrite_i) ? rd_mux : 32'h0000_0000;

    mode_next = mode_reg;
    mask_next = mask_reg;
    rx_on_next = rx_on_reg;
    tx_on_next = tx_on_reg;
    rx_ptr_next = rx_ptr_reg;
    rx_cnt_next = rx_cnt_reg;
    tx_ptr_next = tx_ptr_reg;
    tx_cnt_next = tx_cnt_reg;
    state_next = state_reg;
    mem_req_next = mem_req_reg;
    mem_we_next = mem_we_reg;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    tx_valid_next = tx_valid_reg;
    tx_data_next = tx_data_reg;
    buf_pop = 1'b0;

    if (tx_valid_reg & tx_ready_i)
      tx_valid_next = 1'b0;

    // Channel engine; receive has priority over transmit
    case (state_reg)
      periph_reg_pkg::CH_IDLE:
      begin
        if (rx_on_reg & (rx_cnt_reg != 16'h0000) & buf_valid)
        begin
          buf_pop = 1'b1;
          mem_req_next = 1'b1;
          mem_we_next = 1'b1;
          mem_addr_next = rx_ptr_reg;
          mem_wdata_next = buf_data;
          state_next = periph_reg_pkg::CH_RX_WR;
        end
        else if (tx_on_reg & (tx_cnt_reg != 16'h0000) & ~tx_valid_reg)
        begin
          mem_req_next = 1'b1;
          mem_we_next = 1'b0;
          mem_addr_next = tx_ptr_reg;
          state_next = periph_reg_pkg::CH_TX_RD;
        end
      end
      periph_reg_pkg::CH_RX_WR:
      begin
        if (mem_ack_i)
        begin
          mem_req_next = 1'b0;
          mem_we_next = 1'b0;
          rx_ptr_next = rx_ptr_reg + item_step(mode_reg);
          rx_cnt_next = rx_cnt_reg - 16'h0001;
          state_next = periph_reg_pkg::CH_IDLE;
        end
      end
      periph_reg_pkg::CH_TX_RD:
      begin
        if (mem_ack_i)
        begin
          mem_req_next = 1'b0;
          tx_data_next = mem_rdata_i;
          tx_valid_next = 1'b1;
          tx_ptr_next = tx_ptr_reg + item_step(mode_reg);
          tx_cnt_next = tx_cnt_reg - 16'h0001;
          state_next = periph_reg_pkg::CH_IDLE;
        end
      end
      default:
      begin
        mem_req_next = 1'b0;
        state_next = periph_reg_pkg::CH_IDLE;
      end
    endcase

    // Register writes take effect at the end of the access phase; they win over the engine
    if (wr_done)
    begin
      case (offset)
        `OFF_CTRL:
        begin
          // Ones launch commands, zeros do nothing; stop beats start on the same channel
          if (pwdata_i[`CTRL_RX_START])
            rx_on_next = 1'b1;
          if (pwdata_i[`CTRL_RX_STOP])
            rx_on_next = 1'b0;
          if (pwdata_i[`CTRL_TX_START])
            tx_on_next = 1'b1;
          if (pwdata_i[`CTRL_TX_STOP])
            tx_on_next = 1'b0;
        end
        `OFF_MODE: mode_next = pwdata_i[`MODE_SIZE_MSB:`MODE_SIZE_LSB];
        `OFF_IRQ_EN: mask_next = mask_reg | pwdata_i[`ST_WIDTH-1:0];
        `OFF_IRQ_DIS: mask_next = mask_reg & ~pwdata_i[`ST_WIDTH-1:0];
        `OFF_RX_PTR: rx_ptr_next = pwdata_i;
        `OFF_RX_CNT: rx_cnt_next = pwdata_i[15:0];
        `OFF_TX_PTR: tx_ptr_next = pwdata_i;
        `OFF_TX_CNT: tx_cnt_next = pwdata_i[15:0];
        // Status and mask registers are read-only; writes fall here and are dropped
        default: mode_next = mode_reg;
      endcase
    end

    irq_next = |(status & mask_reg);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
      mode_reg <= `RST_MODE;
      mask_reg <= `RST_MASK;
      rx_on_reg <= 1'b0;
      tx_on_reg <= 1'b0;
      rx_ptr_reg <= `RST_PTR;
      rx_cnt_reg <= `RST_CNT;
      tx_ptr_reg <= `RST_PTR;
      tx_cnt_reg <= `RST_CNT;
      state_reg <= periph_reg_pkg::CH_IDLE;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 32'h0000_0000;
      mem_wdata_reg <= 32'h0000_0000;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 32'h0000_0000;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= 1'b0;
      irq_reg <= irq_next;
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      rx_on_reg <= rx_on_next;
      tx_on_reg <= tx_on_next;
      rx_ptr_reg <= rx_ptr_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_ptr_reg <= tx_ptr_next;
      tx_cnt_reg <= tx_cnt_next;
      state_reg <= state_next;
      mem_req_reg <= mem_req_next;
      mem_we_reg <= mem_we_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign irq_o = irq_reg;
  assign mem_req_o = mem_req_reg;
  assign mem_we_o = mem_we_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_data_o = tx_data_reg;

endmodule // peripheral_register_interface

`default_nettype wire

/* File: verilog/two_entry_buffer.sv */
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Ready and valid outputs come from flip-flops
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  logic [WIDTH-1:0] slot0_reg, slot0_next;
  logic [WIDTH-1:0] slot1_reg, slot1_next;
  logic [1:0] count_reg, count_next;
  logic ready_reg, ready_next;
  logic valid_reg, valid_next;
  logic push, pop;

  always_comb
  begin
    push = in_valid_i & ready_reg;
    pop = valid_reg & out_ready_i;
    slot0_next = slot0_reg;
    slot1_next = slot1_reg;
    count_next = count_reg;
    case ({push, pop})
      2'b10:
      begin
        if (count_reg == 2'd0)
          slot0_next = in_data_i;
        else
          slot1_next = in_data_i;
        count_next = count_reg + 2'd1;
      end
      2'b01:
      begin
        slot0_next = slot1_reg;
        count_next = count_reg - 2'd1;
      end
      2'b11:
      begin
        // Only reachable with one entry held: new word replaces the leaving one
        slot0_next = in_data_i;
      end
      default:
      begin
        count_next = count_reg;
      end
    endcase
    ready_next = (count_next != 2'd2);
    valid_next = (count_next != 2'd0);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      slot0_reg <= '0;
      slot1_reg <= '0;
      count_reg <= 2'd0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      slot0_reg <= slot0_next;
      slot1_reg <= slot1_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
      valid_reg <= valid_next;
    end
  end

  assign in_ready_o = ready_reg;
  assign out_valid_o = valid_reg;
  assign out_data_o = slot0_reg;

endmodule // two_entry_buffer

`default_nettype wire
